// [rtl/cbdf_top.sv]
`timescale 1ns/1ps
`include "cbdf_regs.svh"
// Contract
// - Each dropped receive frame adds one to the 32-bit discard tally.
// - Reading the tally returns it and then clears it; resets to zero.
// - Tally stepping from 7fffffff to 80000000 raises a halfway event.
// - Writing one to the busy bit starts the selected indirect MAC access.
// - Busy stays one for the whole access, clears itself when it finishes.
// - After an indirect read finishes, the data register holds the fetched value.
// - Direction bit: one reads the MAC register, zero writes it; resets zero.
// - Eight-bit address field selects the MAC register; resets zero.
// - 32-bit data register carries write value or read result; resets zero.
// - No pause frames or jamming while the transmitter is disabled.
// - High threshold in 64-byte units triggers flow control; resets zero.
// - At high threshold jam according to the four trigger bits, or pause only when the any-frame bit is set.
// - Full duplex sends one pause frame carrying the MAC pause time.
// - Half duplex jams each matching frame for the duration code period.
// - Below low threshold after a pause, send a zero-time pause frame.
// - Four-bit duration code sets jam length; unused in full duplex.
// - Half duplex trigger bits for multicast, broadcast and own-address frames.
// - Any-frame trigger covers all frames and overrides the three others.
module cbdf_top #(
	parameter int JAM_CLK_MHZ = `CBDF_CLK_MHZ,
	parameter int JAM_W       = 18
) (
	input  wire logic                  ref_clk,
	input  wire logic                  arst_n,
	input  wire logic                  reg_rd,
	input  wire logic                  reg_wr,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	output logic      [31:0]           reg_rdata,
	input  wire logic                  rx_drop,
	output logic                       drop_half_evt,
	output cbdf_pkg::cbdf_mac_req_t    mac_req,
	input  wire logic                  mac_ack,
	input  wire logic [31:0]           mac_rdata,
	input  wire logic                  tx_enabled,
	input  wire logic                  full_duplex,
	input  wire logic                  link_fast,
	input  wire logic [7:0]            rx_fill_units,
	input  cbdf_pkg::cbdf_frame_t      frame_info,
	output logic                       pause_req,
	output logic                       pause_zero,
	output logic                       jam
);
	logic [31:0]                 tally_r, tally_nxt;
	logic [31:0]                 rdata_r, rdata_nxt;
	logic                        half_r, half_nxt;
	cbdf_pkg::cbdf_ind_state_t   st_r, st_nxt;
	logic                        rnw_r, rnw_nxt;
	logic [7:0]                  maddr_r, maddr_nxt;
	logic [31:0]                 mdata_r, mdata_nxt;
	logic [7:0]                  hi_r, hi_nxt;
	logic [7:0]                  lo_r, lo_nxt;
	logic [3:0]                  dur_r, dur_nxt;
	logic [3:0]                  trig_r, trig_nxt;
	logic                        sent_r, sent_nxt;
	logic                        preq_r, preq_nxt;
	logic                        pzero_r, pzero_nxt;
	logic [JAM_W-1:0]            jcnt_r, jcnt_nxt;
	logic                        jam_r, jam_nxt;

	// Jam length in cycles, rounded up, from the duration code and link speed.
	function automatic logic [JAM_W-1:0] jam_cycles(input logic [3:0] code, input logic fast);
		int tenths;
		tenths = 0;
		if (code < 4'h3) begin
			tenths = `CBDF_JAM_FAST_BASE_TENTHS_US * (int'(code) + 1);
		end else if (code == 4'h3) begin
			tenths = `CBDF_JAM_FAST_BASE_TENTHS_US * 5;
		end else begin
			tenths = `CBDF_JAM_FAST_BASE_TENTHS_US * 10 * (int'(code) - 3);
		end
		if (!fast) begin
			tenths = tenths + `CBDF_JAM_SLOW_EXTRA_TENTHS_US;
		end
		return JAM_W'((tenths * JAM_CLK_MHZ + `CBDF_TENTHS_PER_US - 1) / `CBDF_TENTHS_PER_US);
	endfunction : jam_cycles

	function automatic logic hit(input logic [7:0] a);
		return (reg_addr == a);
	endfunction : hit

	logic busy;
	assign busy = (st_r == cbdf_pkg::CBDF_WAIT);

	always_comb begin
		tally_nxt = tally_r;
		rdata_nxt = rdata_r;
		half_nxt  = 1'b0;
		st_nxt    = st_r;
		rnw_nxt   = rnw_r;
		maddr_nxt = maddr_r;
		mdata_nxt = mdata_r;
		hi_nxt    = hi_r;
		lo_nxt    = lo_r;
		dur_nxt   = dur_r;
		trig_nxt  = trig_r;
		if (reg_rd) begin
			if (hit(`CBDF_OFS_DROP_COUNT)) begin
				rdata_nxt = tally_r;
			end else if (hit(`CBDF_OFS_IND_CMD)) begin
				rdata_nxt = {busy, rnw_r, 22'h000000, maddr_r};
			end else if (hit(`CBDF_OFS_IND_DATA)) begin
				rdata_nxt = mdata_r;
			end else if (hit(`CBDF_OFS_PAUSE_CFG)) begin
				rdata_nxt = {8'h00, hi_r, lo_r, dur_r, trig_r};
			end else begin
				rdata_nxt = 32'h00000000;
			end
		end
		// The drop is applied after the clear so that a read never swallows one.
		if (reg_rd && hit(`CBDF_OFS_DROP_COUNT)) begin
			tally_nxt = {31'h00000000, rx_drop};
		end else if (rx_drop) begin
			tally_nxt = tally_r + 32'h00000001;
		end
		if (rx_drop && tally_r == `CBDF_DROP_MID_BELOW && !(reg_rd && hit(`CBDF_OFS_DROP_COUNT))) begin
			half_nxt = 1'b1;
		end
		// Command and data writes during a pending access are dropped rather than corrupting it.
		if (reg_wr && !busy) begin
			if (hit(`CBDF_OFS_IND_CMD)) begin
				rnw_nxt   = reg_wdata[`CBDF_CMD_RNW_BIT];
				maddr_nxt = reg_wdata[`CBDF_CMD_ADDR_MSB:0];
				if (reg_wdata[`CBDF_CMD_BUSY_BIT]) begin
					st_nxt = cbdf_pkg::CBDF_WAIT;
				end
			end
			if (hit(`CBDF_OFS_IND_DATA)) begin
				mdata_nxt = reg_wdata;
			end
		end
		if (reg_wr && hit(`CBDF_OFS_PAUSE_CFG)) begin
			hi_nxt   = reg_wdata[`CBDF_CFG_HI_MSB:`CBDF_CFG_HI_LSB];
			lo_nxt   = reg_wdata[`CBDF_CFG_LO_MSB:`CBDF_CFG_LO_LSB];
			dur_nxt  = reg_wdata[`CBDF_CFG_DUR_MSB:`CBDF_CFG_DUR_LSB];
			trig_nxt = reg_wdata[`CBDF_CFG_MCAST_BIT:`CBDF_CFG_ANY_BIT];
		end
		case (st_r)
			cbdf_pkg::CBDF_IDLE: begin
			end
			cbdf_pkg::CBDF_WAIT: begin
				if (mac_ack) begin
					st_nxt = cbdf_pkg::CBDF_IDLE;
					if (rnw_r) begin
						mdata_nxt = mac_rdata;
					end
				end
			end
			default: begin
				st_nxt = cbdf_pkg::CBDF_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tally_r <= `CBDF_RST_WORD;
			rdata_r <= `CBDF_RST_WORD;
			half_r  <= 1'b0;
			st_r    <= cbdf_pkg::CBDF_IDLE;
			rnw_r   <= 1'b0;
			maddr_r <= 8'h00;
			mdata_r <= `CBDF_RST_WORD;
			hi_r    <= 8'h00;
			lo_r    <= 8'h00;
			dur_r   <= 4'h0;
			trig_r  <= 4'h0;
		end else begin
			tally_r <= tally_nxt;
			rdata_r <= rdata_nxt;
			half_r  <= half_nxt;
			st_r    <= st_nxt;
			rnw_r   <= rnw_nxt;
			maddr_r <= maddr_nxt;
			mdata_r <= mdata_nxt;
			hi_r    <= hi_nxt;
			lo_r    <= lo_nxt;
			dur_r   <= dur_nxt;
			trig_r  <= trig_nxt;
		end
	end

	logic at_hi;
	logic fd_pause_on;
	logic hd_match;
	assign at_hi       = (rx_fill_units >= hi_r);
	assign fd_pause_on = trig_r[`CBDF_CFG_ANY_BIT];
	assign hd_match    = trig_r[`CBDF_CFG_ANY_BIT] ? frame_info.start :
		(frame_info.addr_valid && ((frame_info.mcast && trig_r[`CBDF_CFG_MCAST_BIT]) ||
		(frame_info.bcast && trig_r[`CBDF_CFG_BCAST_BIT]) || (frame_info.own && trig_r[`CBDF_CFG_OWN_BIT])));

	always_comb begin
		sent_nxt  = sent_r;
		preq_nxt  = 1'b0;
		pzero_nxt = pzero_r;
		jcnt_nxt  = jcnt_r;
		if (jcnt_r != '0) begin
			jcnt_nxt = jcnt_r - JAM_W'(1);
		end
		if (!tx_enabled) begin
			jcnt_nxt = '0;
		end else if (full_duplex) begin
			jcnt_nxt = '0;
			if (fd_pause_on && at_hi && !sent_r) begin
				preq_nxt  = 1'b1;
				pzero_nxt = 1'b0;
				sent_nxt  = 1'b1;
			end else if (fd_pause_on && sent_r && rx_fill_units < lo_r) begin
				preq_nxt  = 1'b1;
				pzero_nxt = 1'b1;
				sent_nxt  = 1'b0;
			end
		end else if (at_hi && hd_match) begin
			jcnt_nxt = jam_cycles(dur_r, link_fast);
		end
		jam_nxt = (jcnt_nxt != '0);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sent_r  <= 1'b0;
			preq_r  <= 1'b0;
			pzero_r <= 1'b0;
			jcnt_r  <= '0;
			jam_r   <= 1'b0;
		end else begin
			sent_r  <= sent_nxt;
			preq_r  <= preq_nxt;
			pzero_r <= pzero_nxt;
			jcnt_r  <= jcnt_nxt;
			jam_r   <= jam_nxt;
		end
	end

	assign reg_rdata     = rdata_r;
	assign drop_half_evt = half_r;
	assign mac_req.req   = busy;
	assign mac_req.rnw   = rnw_r;
	assign mac_req.addr  = maddr_r;
	assign mac_req.wdata = mdata_r;
	assign pause_req     = preq_r;
	assign pause_zero    = pzero_r;
	assign jam           = jam_r;

	logic rd_tally;
	assign rd_tally = reg_rd && (reg_addr == `CBDF_OFS_DROP_COUNT);

	property p_drop_inc;
		@(posedge ref_clk) disable iff (!arst_n)
		(rx_drop && !rd_tally) |=> (tally_r == $past(tally_r) + 32'h00000001);
	endproperty
	a_drop_inc: assert property (p_drop_inc) else $error("drop did not add one");

	property p_rc_clear;
		@(posedge ref_clk) disable iff (!arst_n)
		rd_tally |=> (reg_rdata == $past(tally_r)) && (tally_r == {31'h00000000, $past(rx_drop)});
	endproperty
	a_rc_clear: assert property (p_rc_clear) else $error("tally read did not clear");

	property p_half;
		@(posedge ref_clk) disable iff (!arst_n)
		(tally_r == `CBDF_DROP_MID_BELOW && rx_drop && !rd_tally) |=> drop_half_evt ##1 !drop_half_evt;
	endproperty
	a_half: assert property (p_half) else $error("halfway event missing");

	property p_start;
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == `CBDF_OFS_IND_CMD && reg_wdata[`CBDF_CMD_BUSY_BIT] && !mac_req.req)
			|=> mac_req.req && (mac_req.addr == $past(reg_wdata[7:0]));
	endproperty
	a_start: assert property (p_start) else $error("indirect access not started");

	property p_busy_hold;
		@(posedge ref_clk) disable iff (!arst_n)
		(mac_req.req && !mac_ack) |=> mac_req.req;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

	property p_rd_data;
		@(posedge ref_clk) disable iff (!arst_n)
		(mac_req.req && mac_ack && mac_req.rnw) |=> !mac_req.req && (mac_req.wdata == $past(mac_rdata));
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data not captured");

	property p_tx_off;
		@(posedge ref_clk) disable iff (!arst_n)
		!tx_enabled |=> !pause_req && !jam;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("flow control with transmitter off");

	property p_one_pause;
		@(posedge ref_clk) disable iff (!arst_n)
		(pause_req && !pause_zero) |=> !(pause_req && !pause_zero) [*8];
	endproperty
	a_one_pause: assert property (p_one_pause) else $error("second pause frame");

	property p_reserved;
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `CBDF_OFS_PAUSE_CFG) |=> (reg_rdata[31:24] == 8'h00);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

	c_ind_read: cover property (@(posedge ref_clk) disable iff (!arst_n) mac_req.req && mac_req.rnw && mac_ack);
	c_pause: cover property (@(posedge ref_clk) disable iff (!arst_n) pause_req && !pause_zero ##[1:50] pause_req && pause_zero);
	c_jam: cover property (@(posedge ref_clk) disable iff (!arst_n) !jam ##1 jam);
	c_half: cover property (@(posedge ref_clk) disable iff (!arst_n) drop_half_evt);
endmodule : cbdf_top

// [rtl/cbdf_regs.svh]
`ifndef CBDF_REGS_SVH
`define CBDF_REGS_SVH
`define CBDF_OFS_DROP_COUNT   8'ha0
`define CBDF_OFS_IND_CMD      8'ha4
`define CBDF_OFS_IND_DATA     8'ha8
`define CBDF_OFS_PAUSE_CFG    8'hac
`define CBDF_CMD_BUSY_BIT     31
`define CBDF_CMD_RNW_BIT      30
`define CBDF_CMD_ADDR_MSB     7
`define CBDF_CFG_HI_MSB       23
`define CBDF_CFG_HI_LSB       16
`define CBDF_CFG_LO_MSB       15
`define CBDF_CFG_LO_LSB       8
`define CBDF_CFG_DUR_MSB      7
`define CBDF_CFG_DUR_LSB      4
`define CBDF_CFG_MCAST_BIT    3
`define CBDF_CFG_BCAST_BIT    2
`define CBDF_CFG_OWN_BIT      1
`define CBDF_CFG_ANY_BIT      0
`define CBDF_RST_WORD         32'h00000000
`define CBDF_DROP_MID_BELOW   32'h7fffffff
`define CBDF_DROP_MID         32'h80000000
`define CBDF_CLK_MHZ          125
`define CBDF_JAM_FAST_BASE_TENTHS_US 50
`define CBDF_JAM_SLOW_EXTRA_TENTHS_US 22
`define CBDF_TENTHS_PER_US    10
`endif

// [rtl/cbdf_pkg.sv]
package cbdf_pkg;
	typedef enum logic [1:0] {
		CBDF_IDLE = 2'b01,
		CBDF_WAIT = 2'b10
	} cbdf_ind_state_t;

	typedef struct packed {
		logic start;
		logic addr_valid;
		logic mcast;
		logic bcast;
		logic own;
	} cbdf_frame_t;

	typedef struct packed {
		logic        req;
		logic        rnw;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} cbdf_mac_req_t;
endpackage : cbdf_pkg

// [sim/cbdf_mac_model.sv]
`timescale 1ns/1ps
module cbdf_mac_model (
	input  wire logic               ref_clk,
	input  wire logic               arst_n,
	input  wire logic [3:0]         lat,
	input  cbdf_pkg::cbdf_mac_req_t mac_req,
	output logic                    mac_ack,
	output logic      [31:0]        mac_rdata
);
	logic [31:0] mem [256];
	logic [3:0]  wait_r;
	logic        done_r;
	// Between answers the read bus flips every cycle, so stale data never passes for a result.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mac_ack   <= 1'b0;
			mac_rdata <= 32'h00000000;
			wait_r    <= 4'h0;
			done_r    <= 1'b0;
		end else begin
			mac_ack   <= 1'b0;
			mac_rdata <= ~mac_rdata;
			if (!mac_req.req) begin
				wait_r <= 4'h0;
				done_r <= 1'b0;
			end else if (!done_r && wait_r < lat) begin
				wait_r <= wait_r + 4'h1;
			end else if (!done_r) begin
				mac_ack <= 1'b1;
				done_r  <= 1'b1;
				if (mac_req.rnw) begin
					mac_rdata <= mem[mac_req.addr];
				end else begin
					mem[mac_req.addr] <= mac_req.wdata;
				end
			end
		end
	end
endmodule : cbdf_mac_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic                    ref_clk, arst_n, reg_rd, reg_wr, rx_drop, mac_ack, drop_half_evt;
	logic                    tx_enabled, full_duplex, link_fast, pause_req, pause_zero, jam;
	logic [7:0]              reg_addr, rx_fill_units;
	logic [31:0]             reg_wdata, reg_rdata, mac_rdata, rd;
	logic [3:0]              lat;
	cbdf_pkg::cbdf_mac_req_t mac_req;
	cbdf_pkg::cbdf_frame_t   frame_info;
	int                      err_count, comparisons, n, np, nj;

	always #4 ref_clk = ~ref_clk;

	cbdf_top #(.JAM_CLK_MHZ(1)) cbdf_top_inst (.ref_clk(ref_clk), .arst_n(arst_n), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.rx_drop(rx_drop), .drop_half_evt(drop_half_evt), .mac_req(mac_req), .mac_ack(mac_ack),
		.mac_rdata(mac_rdata), .tx_enabled(tx_enabled), .full_duplex(full_duplex), .link_fast(link_fast),
		.rx_fill_units(rx_fill_units), .frame_info(frame_info), .pause_req(pause_req),
		.pause_zero(pause_zero), .jam(jam));
	cbdf_mac_model cbdf_mac_model_inst (.ref_clk(ref_clk), .arst_n(arst_n), .lat(lat), .mac_req(mac_req),
		.mac_ack(mac_ack), .mac_rdata(mac_rdata));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : tick

	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		tick(1);
		reg_wr = wr;
		reg_rd = !wr;
		reg_addr = a;
		reg_wdata = d;
		tick(1);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rd = reg_rdata;
	endtask : bus

	task watch(input int k);
		np = 0;
		nj = 0;
		repeat (k) begin
			tick(1);
			np += int'(pause_req);
			nj += int'(jam);
		end
	endtask : watch

	task wait_idle;
		n = 0;
		do begin
			bus(1'b0, 8'ha4, 32'h0);
			n++;
		end while (rd[31] !== 1'b0 && n < 40);
		chk(32'(rd[31]), 32'h0);
	endtask : wait_idle

	task wait_pause(input logic z);
		n = 0;
		while (pause_req !== 1'b1 && n < 10) begin
			tick(1);
			n++;
		end
		chk(32'(pause_req), 32'h1);
		chk(32'(pause_zero), 32'(z));
	endtask : wait_pause

	task frame_jam(input cbdf_pkg::cbdf_frame_t f, input int exp);
		int j0;
		frame_info = f;
		tick(1);
		frame_info = '0;
		// Jam rises at the edge that takes the trigger, so that first cycle is counted here.
		j0 = int'(jam);
		watch(20);
		chk(32'(nj + j0), 32'(exp));
	endtask : frame_jam

	task t_reset;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 8'ha0 + 8'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
	endtask : t_reset

	task t_tally;
		for (int i = 0; i < 3; i++) begin
			rx_drop = 1'b1;
			tick(1);
			rx_drop = 1'b0;
			tick(1);
		end
		bus(1'b0, 8'ha0, 32'h0);
		chk(rd, 32'h3);
		reg_rd = 1'b1;
		reg_addr = 8'ha0;
		rx_drop = 1'b1;
		tick(1);
		reg_rd = 1'b0;
		rx_drop = 1'b0;
		chk(reg_rdata, 32'h0);
		bus(1'b0, 8'ha0, 32'h0);
		chk(rd, 32'h1);
		bus(1'b0, 8'ha0, 32'h0);
		chk(rd, 32'h0);
	endtask : t_tally

	task t_ind;
		lat = 4'h6;
		bus(1'b1, 8'ha8, 32'h5a5a1234);
		bus(1'b1, 8'ha4, 32'h80000012);
		bus(1'b0, 8'ha4, 32'h0);
		chk(rd, 32'h80000012);
		bus(1'b1, 8'ha8, 32'hffffffff);
		wait_idle();
		bus(1'b0, 8'ha8, 32'h0);
		chk(rd, 32'h5a5a1234);
		lat = 4'h1;
		bus(1'b1, 8'ha8, 32'h0);
		bus(1'b1, 8'ha4, 32'hc0000012);
		wait_idle();
		bus(1'b0, 8'ha8, 32'h0);
		chk(rd, 32'h5a5a1234);
		bus(1'b1, 8'ha4, 32'h7fffff34);
		bus(1'b0, 8'ha4, 32'h0);
		chk(rd, 32'h40000034);
	endtask : t_ind

	task t_full;
		tx_enabled = 1'b1;
		full_duplex = 1'b1;
		bus(1'b1, 8'hac, 32'hff050201);
		bus(1'b0, 8'hac, 32'h0);
		chk(rd, 32'h00050201);
		rx_fill_units = 8'h05;
		wait_pause(1'b0);
		watch(10);
		chk(32'(np), 32'h0);
		rx_fill_units = 8'h01;
		wait_pause(1'b1);
	endtask : t_full

	task t_half;
		full_duplex = 1'b0;
		link_fast = 1'b1;
		bus(1'b1, 8'hac, 32'h00000008);
		frame_jam(5'b01100, 5);
		link_fast = 1'b0;
		frame_jam(5'b01100, 8);
		frame_jam(5'b01010, 0);
		bus(1'b1, 8'hac, 32'h00000019);
		frame_jam(5'b01100, 0);
		link_fast = 1'b1;
		frame_jam(5'b10000, 10);
		tx_enabled = 1'b0;
		frame_jam(5'b10000, 0);
		chk(32'(np), 32'h0);
	endtask : t_half

	task test_done;
		$display("Errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	initial begin
		{ref_clk, arst_n, reg_rd, reg_wr, rx_drop, tx_enabled, full_duplex, link_fast} = '0;
		{reg_addr, rx_fill_units, reg_wdata, rd} = '0;
		frame_info = '0;
		lat = 4'h1;
		err_count = 0;
		comparisons = 0;
		repeat (4) @(posedge ref_clk);
		#1;
		arst_n = 1'b1;
		t_reset();
		t_tally();
		t_ind();
		t_full();
		t_half();
		test_done();
	end

	// Whole run needs well under a thousand cycles; this leaves a wide margin.
	initial begin
		#200000;
		err_count++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		test_done();
	end
endmodule : testbench
